// ---- shared/smig_map.svh ----
/*
  Register offsets, bit positions, reset values and command codes for the
  status/mode/interrupt gate. Assumes inclusion by bare name.
*/
`ifndef SMIG_MAP_SVH
`define SMIG_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SMIG_OFF_STATUS 12'h000
`define SMIG_OFF_EVENT 12'h004
`define SMIG_OFF_CONTROL 12'h008
`define SMIG_OFF_EPC 12'h00c
`define SMIG_OFF_ERROR_EPC 12'h010
`define SMIG_OFF_EVT_PC 12'h014
`define SMIG_OFF_VIEW 12'h018
`define SMIG_OFF_SHADOW 12'h01c

// ****************************************
// Status field positions
// ****************************************
`define SMIG_BIT_IRQ_GATE 0
`define SMIG_BIT_EXC_LEVEL 1
`define SMIG_BIT_ERR_LEVEL 2
`define SMIG_BIT_RESERVED 3
`define SMIG_BIT_USER_BASE 4

// ****************************************
// Event register fields
// ****************************************
`define SMIG_EVT_CODE_LO 0
`define SMIG_EVT_CODE_HI 3
`define SMIG_EVT_BD_BIT 8
`define SMIG_EVT_SHADOW_LO 16
`define SMIG_EVT_SHADOW_HI 19

// ****************************************
// Event codes written to the event register
// ****************************************
`define SMIG_CMD_NONE 4'h0
`define SMIG_CMD_RESET 4'h1
`define SMIG_CMD_SOFT_RESET 4'h2
`define SMIG_CMD_NMI 4'h3
`define SMIG_CMD_CACHE_ERR 4'h4
`define SMIG_CMD_GENERAL 4'h5
`define SMIG_CMD_TLB_REFILL 4'h6
`define SMIG_CMD_EXCEPTION_RETURN_INSN 4'h7
`define SMIG_CMD_IRQ_OFF 4'h8
`define SMIG_CMD_IRQ_ON 4'h9
`define SMIG_CMD_INTERRUPT 4'ha

// ****************************************
// Vectors and reset values
// ****************************************
`define SMIG_VEC_GENERAL 32'h0000_0180
`define SMIG_VEC_TLB_REFILL 32'h0000_0000
`define SMIG_VEC_ERROR 32'h0000_0100
`define SMIG_RST_STATUS 5'h04
`define SMIG_RST_WORD 32'h0000_0000
`define SMIG_CTRL_SUPV_BIT 0
`define SMIG_CTRL_REL2_BIT 1
`define SMIG_RST_CONTROL 2'h2

`endif

// ---- shared/smig_pkg.sv ----
/*
  Types for the status/mode/interrupt gate. Assumes smig_map.svh supplies
  the numeric constants.
*/
package smig_pkg;

  // Low status fields as held by hardware
  typedef struct packed {
    logic user_base_select;
    logic reserved_status_bit;
    logic error_level_flag;
    logic exception_level_flag;
    logic master_irq_gate;
  } smig_status_t;

  // Derived view of privilege and routing
  typedef struct packed {
    logic kernel_mode;
    logic irq_accept;
    logic kuseg_unmapped;
    logic tlb_to_general;
  } smig_view_t;

  typedef enum logic [1:0] {
    smig_idle,
    smig_access
  } smig_apb_state_t;

endpackage : smig_pkg

// ---- verilog/smig_word_reg.sv ----
/*
  One 32-bit word register with a load strobe; read data comes out of the
  flip-flops. Assumes pclk / presetn as in the rest of the block.
*/
`timescale 1ns/100ps
`include "smig_map.svh"
module smig_word_reg
  import smig_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Load side
  input wire logic load,
  input wire logic [31:0] load_data,
  // Stored word
  output logic [31:0] value
);

  // Held word, cleared at reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      value <= `SMIG_RST_WORD;
    end
    else if (load)
    begin
      value <= load_data;
    end
  end

endmodule : smig_word_reg

// ---- verilog/smig_gate.sv ----
/*
  Status/mode/interrupt gate: low fields of the processor status register,
  privilege, interrupt acceptance, return target, kuseg mapping and vector
  choice. Software posts core events through an APB event register.
  Assumes an APB master on pclk; one-cycle access phase, no wait states.
*/
// Implementation choices: the address map and register access over APB.
`timescale 1ns/100ps
`include "smig_map.svh"
module smig_gate
  import smig_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core-facing view
  output logic kernel_mode,
  output logic irq_accept,
  output logic kuseg_unmapped,
  output logic [31:0] return_target,
  output logic [31:0] vector_addr
);

  // ****************************************
  // Decode helpers
  // ****************************************

  // Address match used by both read and write paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  // Events that raise the error level
  function automatic logic err_event(input logic [3:0] c);
    err_event = (c == `SMIG_CMD_RESET) || (c == `SMIG_CMD_SOFT_RESET) ||
                (c == `SMIG_CMD_NMI) || (c == `SMIG_CMD_CACHE_ERR);
  endfunction : err_event

  // ****************************************
  // Signals
  // ****************************************
  smig_status_t status;
  smig_status_t next_status;
  smig_view_t view;
  smig_apb_state_t state;
  logic [1:0] control;
  logic [31:0] exc_return_pc;
  logic [31:0] error_epc;
  logic [31:0] evt_pc;
  logic [31:0] cause_word;
  logic [31:0] shadow;
  logic wr_go;
  logic rd_go;
  logic evt_go;
  logic [3:0] evt_code;
  logic evt_bd;
  logic [3:0] evt_shadow;
  logic supv_present;
  logic rel2;
  logic exc_taken;
  logic keep_ctx;
  logic [31:0] next_rdata;
  logic addr_ok;

  assign supv_present = control[`SMIG_CTRL_SUPV_BIT];
  assign rel2 = control[`SMIG_CTRL_REL2_BIT];

  // ****************************************
  // APB slave
  // ****************************************

  // Zero-wait slave: access phase always completes in its first cycle
  assign pready = 1'b1;
  assign addr_ok = hit(paddr, `SMIG_OFF_STATUS) || hit(paddr, `SMIG_OFF_EVENT) ||
                   hit(paddr, `SMIG_OFF_CONTROL) || hit(paddr, `SMIG_OFF_EPC) ||
                   hit(paddr, `SMIG_OFF_ERROR_EPC) || hit(paddr, `SMIG_OFF_EVT_PC) ||
                   hit(paddr, `SMIG_OFF_VIEW) || hit(paddr, `SMIG_OFF_SHADOW);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_go = psel && penable && pwrite && addr_ok && (state == smig_access);
  assign rd_go = psel && !penable && !pwrite;
  assign evt_go = wr_go && hit(paddr, `SMIG_OFF_EVENT);
  assign evt_code = pwdata[`SMIG_EVT_CODE_HI:`SMIG_EVT_CODE_LO];
  assign evt_bd = pwdata[`SMIG_EVT_BD_BIT];
  assign evt_shadow = pwdata[`SMIG_EVT_SHADOW_HI:`SMIG_EVT_SHADOW_LO];

  // Phase tracker; a write only lands in an access phase that followed a setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= smig_idle;
    end
    else
    begin
      case (state)
        smig_idle: state <= (psel && !penable) ? smig_access : smig_idle;
        smig_access: state <= (psel && !penable) ? smig_access : smig_idle;
        default: state <= smig_idle;
      endcase
    end
  end

  // ****************************************
  // Status field update
  // ****************************************

  // Exceptions that save context; nested ones keep it
  assign exc_taken = evt_go && ((evt_code == `SMIG_CMD_GENERAL) ||
                     (evt_code == `SMIG_CMD_TLB_REFILL) ||
                     (evt_code == `SMIG_CMD_INTERRUPT));
  assign keep_ctx = status.exception_level_flag;

  always_comb
  begin
    next_status = status;
    if (wr_go && hit(paddr, `SMIG_OFF_STATUS))
    begin
      next_status = pwdata[`SMIG_BIT_USER_BASE:`SMIG_BIT_IRQ_GATE];
    end
    if (evt_go)
    begin
      case (evt_code)
        `SMIG_CMD_RESET, `SMIG_CMD_SOFT_RESET, `SMIG_CMD_NMI, `SMIG_CMD_CACHE_ERR:
        begin
          next_status.error_level_flag = 1'b1;
        end
        `SMIG_CMD_GENERAL, `SMIG_CMD_TLB_REFILL, `SMIG_CMD_INTERRUPT:
        begin
          next_status.exception_level_flag = 1'b1;
        end
        `SMIG_CMD_EXCEPTION_RETURN_INSN:
        begin
          // Return drops the error level first, else the exception level
          if (status.error_level_flag)
          begin
            next_status.error_level_flag = 1'b0;
          end
          else
          begin
            next_status.exception_level_flag = 1'b0;
          end
        end
        `SMIG_CMD_IRQ_OFF:
        begin
          if (rel2)
          begin
            next_status.master_irq_gate = 1'b0;
          end
        end
        `SMIG_CMD_IRQ_ON:
        begin
          if (rel2)
          begin
            next_status.master_irq_gate = 1'b1;
          end
        end
        default:
        begin
          next_status = next_status;
        end
      endcase
    end
    // Without supervisor mode the reserved bit never holds a one
    if (!supv_present)
    begin
      next_status.reserved_status_bit = 1'b0;
    end
  end

  // Status register; error level comes up set as after a reset exception
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status <= `SMIG_RST_STATUS;
    end
    else
    begin
      status <= next_status;
    end
  end

  // Implementation options written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control <= `SMIG_RST_CONTROL;
    end
    else if (wr_go && hit(paddr, `SMIG_OFF_CONTROL))
    begin
      control <= pwdata[`SMIG_CTRL_REL2_BIT:`SMIG_CTRL_SUPV_BIT];
    end
  end

  // ****************************************
  // Saved context registers
  // ****************************************

  // Exception PC only loads on a first-level exception or by software
  smig_word_reg u_epc (
    .pclk(pclk),
    .presetn(presetn),
    .load((exc_taken && !keep_ctx) || (wr_go && hit(paddr, `SMIG_OFF_EPC))),
    .load_data(exc_taken ? evt_pc : pwdata),
    .value(exc_return_pc)
  );

  // Error PC loads on error-class events
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      error_epc <= `SMIG_RST_WORD;
    end
    else if (evt_go && err_event(evt_code))
    begin
      error_epc <= evt_pc;
    end
    else if (wr_go && hit(paddr, `SMIG_OFF_ERROR_EPC))
    begin
      error_epc <= pwdata;
    end
  end

  // PC of the instruction that raises the next event
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_pc <= `SMIG_RST_WORD;
    end
    else if (wr_go && hit(paddr, `SMIG_OFF_EVT_PC))
    begin
      evt_pc <= pwdata;
    end
  end

  // Branch-delay flag and shadow control stay put on nested exceptions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cause_word <= `SMIG_RST_WORD;
      shadow <= `SMIG_RST_WORD;
    end
    else if (exc_taken && !keep_ctx)
    begin
      cause_word <= {31'h0000_0000, evt_bd};
      shadow <= {28'h000_0000, evt_shadow};
    end
    else if (wr_go && hit(paddr, `SMIG_OFF_SHADOW))
    begin
      shadow <= pwdata;
    end
  end

  // ****************************************
  // Derived view
  // ****************************************

  // Either level overrides the base-mode bit
  always_comb
  begin
    view.kernel_mode = status.error_level_flag || status.exception_level_flag ||
                       !status.user_base_select;
    view.irq_accept = status.master_irq_gate &&
                      !status.exception_level_flag && !status.error_level_flag;
    view.kuseg_unmapped = status.error_level_flag;
    view.tlb_to_general = status.exception_level_flag;
  end

  // Registered outputs so the core sees a stable view
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      kernel_mode <= 1'b1;
      irq_accept <= 1'b0;
      kuseg_unmapped <= 1'b1;
      return_target <= `SMIG_RST_WORD;
      vector_addr <= `SMIG_VEC_ERROR;
    end
    else
    begin
      kernel_mode <= view.kernel_mode;
      irq_accept <= view.irq_accept;
      kuseg_unmapped <= view.kuseg_unmapped;
      return_target <= status.error_level_flag ? error_epc : exc_return_pc;
      if (status.error_level_flag)
      begin
        vector_addr <= `SMIG_VEC_ERROR;
      end
      else if (view.tlb_to_general)
      begin
        vector_addr <= `SMIG_VEC_GENERAL;
      end
      else
      begin
        vector_addr <= `SMIG_VEC_TLB_REFILL;
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************

  // Read data sampled in the setup phase, shown during access
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (hit(paddr, `SMIG_OFF_STATUS))
    begin
      next_rdata[`SMIG_BIT_USER_BASE:`SMIG_BIT_IRQ_GATE] = status;
    end
    else if (hit(paddr, `SMIG_OFF_EVENT))
    begin
      next_rdata = cause_word;
    end
    else if (hit(paddr, `SMIG_OFF_CONTROL))
    begin
      next_rdata[`SMIG_CTRL_REL2_BIT:`SMIG_CTRL_SUPV_BIT] = control;
    end
    else if (hit(paddr, `SMIG_OFF_EPC))
    begin
      next_rdata = exc_return_pc;
    end
    else if (hit(paddr, `SMIG_OFF_ERROR_EPC))
    begin
      next_rdata = error_epc;
    end
    else if (hit(paddr, `SMIG_OFF_EVT_PC))
    begin
      next_rdata = evt_pc;
    end
    else if (hit(paddr, `SMIG_OFF_VIEW))
    begin
      next_rdata[3:0] = view;
    end
    else if (hit(paddr, `SMIG_OFF_SHADOW))
    begin
      next_rdata = shadow;
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= `SMIG_RST_WORD;
    end
    else if (rd_go)
    begin
      prdata <= next_rdata;
    end
  end

endmodule : smig_gate

// ---- sim/smig_gate_chk.sv ----
/*
  Port checker for smig_gate: APB answer and derived mode outputs.
  Assumes one pclk domain and a bind onto every smig_gate instance.
*/
`timescale 1ns/100ps
`include "smig_map.svh"
module smig_gate_chk
  import smig_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core-facing view
  input wire logic kernel_mode,
  input wire logic irq_accept,
  input wire logic kuseg_unmapped,
  input wire logic [31:0] return_target,
  input wire logic [31:0] vector_addr
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Event write of one code; outputs lag status by one cycle, hence ##2
  sequence evt_s(logic [3:0] c);
    psel && penable && pwrite && paddr == `SMIG_OFF_EVENT &&
      pwdata[`SMIG_EVT_CODE_HI:`SMIG_EVT_CODE_LO] == c;
  endsequence
  sequence errpc_wr_s;
    psel && penable && pwrite && paddr == `SMIG_OFF_ERROR_EPC;
  endsequence
  ready_a: assert property (pready)
    else $error("pready low");
  slverr_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  rst_a: assert property ($rose(presetn) |-> kernel_mode && kuseg_unmapped && !irq_accept)
    else $error("reset state wrong");
  err_kern_a: assert property (kuseg_unmapped |-> kernel_mode && !irq_accept)
    else $error("error level not kernel");
  err_vec_a: assert property ((vector_addr == `SMIG_VEC_ERROR) == kuseg_unmapped)
    else $error("error vector mismatch");
  exc_vec_a: assert property (vector_addr == `SMIG_VEC_GENERAL |-> kernel_mode && !irq_accept)
    else $error("exception level not kernel");
  irq_lvl_a: assert property (irq_accept |-> vector_addr == `SMIG_VEC_TLB_REFILL)
    else $error("interrupt accepted at raised level");
  err_set_a: assert property (evt_s(`SMIG_CMD_CACHE_ERR) |-> ##2 kuseg_unmapped && !irq_accept)
    else $error("cache error did not raise level");
  exc_set_a: assert property (evt_s(`SMIG_CMD_GENERAL) |->
    ##2 (vector_addr == `SMIG_VEC_GENERAL || kuseg_unmapped))
    else $error("exception did not raise level");
  err_ret_a: assert property (errpc_wr_s |->
    ##2 (!kuseg_unmapped || return_target == $past(pwdata, 2)))
    else $error("return target not error pc");
endmodule : smig_gate_chk

bind smig_gate smig_gate_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .kernel_mode(kernel_mode), .irq_accept(irq_accept),
  .kuseg_unmapped(kuseg_unmapped), .return_target(return_target), .vector_addr(vector_addr));

// ---- sim/tb_top.sv ----
/*
  Self-checking bench for smig_gate over APB.
  Assumes smig_gate_chk is compiled alongside and bound to the design.
*/
`timescale 1ns/100ps
`include "smig_map.svh"
module tb_top
  import smig_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic kernel_mode, irq_accept, kuseg_unmapped;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, return_target, vector_addr, rd;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  smig_gate dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .kernel_mode(kernel_mode), .irq_accept(irq_accept),
    .kuseg_unmapped(kuseg_unmapped), .return_target(return_target),
    .vector_addr(vector_addr));

  // ****************************************
  // Clock, timeout and verdict
  // ****************************************
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // A hang counts as a mismatch; the tests need well under 2000 cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  task print_verdict();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // ****************************************
  // APB master and output sampling
  // ****************************************
  // One transfer plus an idle cycle, so psel is never set twice in a step
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  // Derived outputs lag status one cycle; look at them mid-cycle
  task automatic outs(input logic [2:0] ev, input logic [31:0] vec);
    @(negedge pclk);
    chk("kernel irq kuseg", {29'h0, ev}, {29'h0, kernel_mode, irq_accept, kuseg_unmapped});
    chk("vector", vec, vector_addr);
    @(posedge pclk);
  endtask : outs

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    xfer(1'b0, `SMIG_OFF_STATUS, 32'h0);
    chk("status", 32'h0000_0004, rd);
    outs(3'b101, `SMIG_VEC_ERROR);
  endtask : t_reset

  task automatic t_modes();
    logic [31:0] wv [6] = '{32'h11, 32'h10, 32'h13, 32'h15, 32'h19, 32'h01};
    logic [31:0] rv [6] = '{32'h11, 32'h10, 32'h13, 32'h15, 32'h11, 32'h01};
    logic [2:0] ov [6] = '{3'b010, 3'b000, 3'b100, 3'b101, 3'b010, 3'b110};
    logic [31:0] vv [6] = '{32'h0, 32'h0, 32'h180, 32'h100, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b1, `SMIG_OFF_STATUS, wv[i]);
      outs(ov[i], vv[i]);
      xfer(1'b0, `SMIG_OFF_STATUS, 32'h0);
      chk("status", rv[i], rd);
    end
  endtask : t_modes

  task automatic t_return();
    xfer(1'b1, `SMIG_OFF_STATUS, 32'h04);
    xfer(1'b1, `SMIG_OFF_EPC, 32'h1000);
    xfer(1'b1, `SMIG_OFF_ERROR_EPC, 32'h2000);
    outs(3'b101, `SMIG_VEC_ERROR);
    chk("return", 32'h2000, return_target);
    xfer(1'b1, `SMIG_OFF_STATUS, 32'h0);
    outs(3'b100, `SMIG_VEC_TLB_REFILL);
    chk("return", 32'h1000, return_target);
  endtask : t_return

  task automatic t_codes();
    logic [3:0] c [7] = '{`SMIG_CMD_RESET, `SMIG_CMD_SOFT_RESET, `SMIG_CMD_NMI,
      `SMIG_CMD_CACHE_ERR, `SMIG_CMD_GENERAL, `SMIG_CMD_TLB_REFILL, `SMIG_CMD_INTERRUPT};
    for (int i = 0; i < 7; i++)
    begin
      xfer(1'b1, `SMIG_OFF_STATUS, 32'h0);
      xfer(1'b1, `SMIG_OFF_EVT_PC, 32'h500 + i);
      xfer(1'b1, `SMIG_OFF_EVENT, {28'h0, c[i]});
      xfer(1'b0, `SMIG_OFF_STATUS, 32'h0);
      chk("status", (i < 4) ? 32'h4 : 32'h2, rd);
      if (i < 4)
      begin
        xfer(1'b0, `SMIG_OFF_ERROR_EPC, 32'h0);
        chk("error pc", 32'h500 + i, rd);
      end
    end
  endtask : t_codes

  // Second exception while already at exception level keeps saved state
  task automatic t_nested();
    logic [31:0] sh;
    xfer(1'b1, `SMIG_OFF_STATUS, 32'h0);
    xfer(1'b1, `SMIG_OFF_EVT_PC, 32'h300);
    xfer(1'b1, `SMIG_OFF_EVENT, 32'h0003_0105);
    xfer(1'b0, `SMIG_OFF_SHADOW, 32'h0);
    sh = 32'h3;
    chk("shadow", sh, rd);
    xfer(1'b1, `SMIG_OFF_EVT_PC, 32'h400);
    xfer(1'b1, `SMIG_OFF_EVENT, 32'h0005_0006);
    outs(3'b100, `SMIG_VEC_GENERAL);
    chk("return", 32'h300, return_target);
    xfer(1'b0, `SMIG_OFF_EVENT, 32'h0);
    chk("branch delay", 32'h1, {31'h0, rd[0]});
    xfer(1'b0, `SMIG_OFF_SHADOW, 32'h0);
    chk("shadow", sh, rd);
    xfer(1'b1, `SMIG_OFF_EVENT, {28'h0, `SMIG_CMD_EXCEPTION_RETURN_INSN});
    xfer(1'b0, `SMIG_OFF_STATUS, 32'h0);
    chk("status", 32'h0, rd);
  endtask : t_nested

  task automatic t_irq();
    xfer(1'b1, `SMIG_OFF_STATUS, 32'h10);
    xfer(1'b1, `SMIG_OFF_EVENT, {28'h0, `SMIG_CMD_IRQ_ON});
    outs(3'b010, 32'h0);
    xfer(1'b1, `SMIG_OFF_EVENT, {28'h0, `SMIG_CMD_IRQ_OFF});
    outs(3'b000, 32'h0);
    xfer(1'b1, `SMIG_OFF_CONTROL, 32'h0);
    xfer(1'b1, `SMIG_OFF_EVENT, {28'h0, `SMIG_CMD_IRQ_ON});
    outs(3'b000, 32'h0);
    xfer(1'b1, `SMIG_OFF_CONTROL, 32'h2);
  endtask : t_irq

  // Unmapped place and the read-only view
  task automatic t_bad();
    xfer(1'b1, 12'h020, 32'hffff_ffff);
    chk("slverr", 32'h1, {31'h0, perr});
    xfer(1'b0, 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, perr});
    chk("rdata", 32'h0, rd);
    xfer(1'b1, `SMIG_OFF_VIEW, 32'h0f);
    xfer(1'b0, `SMIG_OFF_VIEW, 32'h0);
    chk("slverr", 32'h0, {31'h0, perr});
    chk("view", 32'h0, rd);
  endtask : t_bad

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_modes();
    t_return();
    t_codes();
    t_nested();
    t_irq();
    t_bad();
    print_verdict();
  end
endmodule : tb_top
